// >>> terminal_status_lamp_control.sv
// Overview of operation
// - after reset the status word is ignored until software first changes it
// - status actions happen only on a changed bit, steady levels repeat nothing
// - bit 15 display on, bit 13 continuous buzzer, bit 12 intermittent buzzer
// - both buzzer bits cleared silences the buzzer
// - each lamp or switch control bit: zero off, one lit or flashing
// - per-indicator preset attribute picks steady or flashing, not the control bit
// - touch switch lit by highlighting its image, no separate lamp
// - separate notify bits report whether each touch switch was pressed
// - lamps follow their control bits continuously with no handshake
// - both buzzer bits set selects the continuous buzzer
// - intermittent buzzer sounds 0.5 s on, 0.5 s off while requested
`timescale 1ns/10ps
module terminal_status_lamp_control #(
   parameter int NUM_LAMP = 8,
   parameter int NUM_SW   = 8,
   parameter int HALF_CYC = lamp_ctrl_pkg::BEEP_HALF_CYC
) (
   input  wire logic                ref_clk,
   input  wire logic                rst_b,
   input  wire logic [3:0]          regAddr,
   input  wire logic [15:0]         regWrData,
   input  wire logic                regWrStb,
   input  wire logic                regRdStb,
   output logic      [15:0]         regRdData,
   input  wire logic [NUM_SW-1:0]   swPressed,
   output logic                     screenOn,
   output logic                     buzzer,
   output logic      [NUM_LAMP-1:0] lampOn,
   output logic      [NUM_SW-1:0]   swHighlight
);
   localparam int NIND = NUM_LAMP + NUM_SW;
   localparam int CW   = $clog2(HALF_CYC + 1);

   // refused at elaboration: indicators share one 16-bit register, divider needs two counts
   if (NUM_LAMP < 1 || NUM_SW < 1 || NIND > 16 || HALF_CYC < 2) begin : g_bad_param
      $error("unsupported parameter values");
   end

   ////////////////////////////////////////////////////////////////////////////
   logic rstSync1_q, rstSync2_q;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstSync1_q <= 1'b0;
         rstSync2_q <= 1'b0;
      end else begin
         rstSync1_q <= 1'b1;
         rstSync2_q <= rstSync1_q;
      end
   end
   wire rstN = rstSync2_q;

   logic [NUM_SW-1:0] pressS1_q, pressS2_q;
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         pressS1_q <= '0;
         pressS2_q <= '0;
      end else begin
         pressS1_q <= swPressed;
         pressS2_q <= pressS1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [15:0]     statusWord_q, statusWord_d;
   logic [15:0]     lastWord_q, lastWord_d;
   logic            armed_q, armed_d;
   logic            dispReq_q, dispReq_d;
   logic            contReq_q, contReq_d;
   logic            interReq_q, interReq_d;
   logic [NIND-1:0] ctrlBits_q, ctrlBits_d;
   logic [NIND-1:0] flashAttr_q, flashAttr_d;
   logic [NUM_SW-1:0] pressLatch_q, pressLatch_d;
   logic [15:0]     rdData_d;
   logic [15:0]     changed;

   always_comb begin
      statusWord_d = statusWord_q;
      lastWord_d   = lastWord_q;
      armed_d      = armed_q;
      dispReq_d    = dispReq_q;
      contReq_d    = contReq_q;
      interReq_d   = interReq_q;
      ctrlBits_d   = ctrlBits_q;
      flashAttr_d  = flashAttr_q;
      // set wins over a software clear in the same cycle
      pressLatch_d = pressLatch_q;
      if (regWrStb && regAddr == lamp_ctrl_pkg::REG_STATUS) begin
         statusWord_d = regWrData;
      end
      if (regWrStb && regAddr == lamp_ctrl_pkg::REG_LAMP) begin
         ctrlBits_d = regWrData[NIND-1:0];
      end
      if (regWrStb && regAddr == lamp_ctrl_pkg::REG_FLASH) begin
         flashAttr_d = regWrData[NIND-1:0];
      end
      if (regWrStb && regAddr == lamp_ctrl_pkg::REG_PRESS) begin
         pressLatch_d = pressLatch_q & ~regWrData[NUM_SW-1:0];     // write one to clear
      end
      pressLatch_d = pressLatch_d | pressS2_q;
      // compare the stored word against the last applied copy
      changed = statusWord_q ^ lastWord_q;
      if (changed != 16'h0000) begin
         lastWord_d = statusWord_q;
         armed_d    = 1'b1;
         // only bits that actually moved are applied
         if (changed[lamp_ctrl_pkg::DISP_BIT])
            dispReq_d = statusWord_q[lamp_ctrl_pkg::DISP_BIT];
         if (changed[lamp_ctrl_pkg::CONT_BIT])
            contReq_d = statusWord_q[lamp_ctrl_pkg::CONT_BIT];
         if (changed[lamp_ctrl_pkg::INTER_BIT])
            interReq_d = statusWord_q[lamp_ctrl_pkg::INTER_BIT];
      end
      unique case (regAddr)
         lamp_ctrl_pkg::REG_STATUS:  rdData_d = statusWord_q;
         lamp_ctrl_pkg::REG_LAMP:    rdData_d = 16'(ctrlBits_q);
         lamp_ctrl_pkg::REG_FLASH:   rdData_d = 16'(flashAttr_q);
         lamp_ctrl_pkg::REG_PRESS:   rdData_d = 16'(pressLatch_q);
         lamp_ctrl_pkg::REG_OUTSTAT: rdData_d = {13'h0, armed_q, buzzer, screenOn};
         default:                    rdData_d = 16'h0000;
      endcase
      if (!regRdStb) rdData_d = 16'h0000;
   end

   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         statusWord_q <= lamp_ctrl_pkg::STATUS_RESET;
         lastWord_q   <= lamp_ctrl_pkg::STATUS_RESET;
         armed_q      <= 1'b0;
         dispReq_q    <= 1'b0;
         contReq_q    <= 1'b0;
         interReq_q   <= 1'b0;
         ctrlBits_q   <= '0;
         flashAttr_q  <= '0;
         pressLatch_q <= '0;
         regRdData    <= 16'h0000;
      end else begin
         statusWord_q <= statusWord_d;
         lastWord_q   <= lastWord_d;
         armed_q      <= armed_d;
         dispReq_q    <= dispReq_d;
         contReq_q    <= contReq_d;
         interReq_q   <= interReq_d;
         ctrlBits_q   <= ctrlBits_d;
         flashAttr_q  <= flashAttr_d;
         pressLatch_q <= pressLatch_d;
         regRdData    <= rdData_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // half-second phase divider for the intermittent buzzer only; indicators flash from flPh_q
   logic [CW-1:0] halfCnt_q, halfCnt_d;
   logic          phase_q, phase_d;
   always_comb begin
      halfCnt_d = halfCnt_q + 1'b1;
      phase_d   = phase_q;
      if (halfCnt_q == CW'(HALF_CYC - 1)) begin
         halfCnt_d = '0;
         phase_d   = ~phase_q;
      end
      // restart so an intermittent request always opens with a full on phase
      if (!interReq_q || contReq_q) begin
         halfCnt_d = '0;
         phase_d   = 1'b0;
      end
   end
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         halfCnt_q <= '0;
         phase_q   <= 1'b0;
      end else begin
         halfCnt_q <= halfCnt_d;
         phase_q   <= phase_d;
      end
   end

   // flashing uses a free-running phase so indicators do not wait on buzzer state
   logic [CW-1:0] flCnt_q;
   logic          flPh_q;
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         flCnt_q <= '0;
         flPh_q  <= 1'b0;
      end else if (flCnt_q == CW'(HALF_CYC - 1)) begin
         flCnt_q <= '0;
         flPh_q  <= ~flPh_q;
      end else begin
         flCnt_q <= flCnt_q + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic          screenOn_d, buzzer_d;
   logic [NIND-1:0] indOn_d, indOn_q;
   always_comb begin
      screenOn_d = dispReq_q;
      buzzer_d   = 1'b0;
      if (contReq_q)
         buzzer_d = 1'b1;
      else if (interReq_q)
         buzzer_d = ~phase_q;                                       // full on phase first
   end
   genvar gi;
   generate
      for (gi = 0; gi < NIND; gi++) begin : g_ind
         // zero is off; one is steady or flashing by attribute
         assign indOn_d[gi] = ctrlBits_q[gi] & (~flashAttr_q[gi] | ~flPh_q);
      end
   endgenerate
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         screenOn <= 1'b0;
         buzzer   <= 1'b0;
         indOn_q  <= '0;
      end else begin
         screenOn <= screenOn_d;
         buzzer   <= buzzer_d;
         indOn_q  <= indOn_d;
      end
   end
   assign lampOn      = indOn_q[NUM_LAMP-1:0];
   assign swHighlight = indOn_q[NIND-1:NUM_LAMP];

   ////////////////////////////////////////////////////////////////////////////
   property p_quiet_until_change;
      @(posedge ref_clk) disable iff (!rstN)
      !armed_q |-> !screenOn && !buzzer;
   endproperty
   a_quiet_until_change: assert property (p_quiet_until_change) else $error("acted before first change");

   property p_steady_no_action;
      @(posedge ref_clk) disable iff (!rstN)
      (statusWord_q == lastWord_q) |=> $stable(dispReq_q) && $stable(contReq_q);
   endproperty
   a_steady_no_action: assert property (p_steady_no_action) else $error("action without change");

   property p_display_follows;
      @(posedge ref_clk) disable iff (!rstN)
      $changed(statusWord_q[lamp_ctrl_pkg::DISP_BIT]) |=>
         ##1 screenOn == $past(statusWord_q[lamp_ctrl_pkg::DISP_BIT], 2);
   endproperty
   a_display_follows: assert property (p_display_follows) else $error("display not applied");

   property p_silence;
      @(posedge ref_clk) disable iff (!rstN)
      (!contReq_q && !interReq_q) |=> !buzzer;
   endproperty
   a_silence: assert property (p_silence) else $error("buzzer not silenced");

   property p_cont_priority;
      @(posedge ref_clk) disable iff (!rstN)
      (contReq_q && interReq_q) [*3] |-> buzzer;
   endproperty
   a_cont_priority: assert property (p_cont_priority) else $error("continuous buzzer lost priority");

   property p_lamp_off;
      @(posedge ref_clk) disable iff (!rstN)
      !ctrlBits_q[0] |=> !lampOn[0];
   endproperty
   a_lamp_off: assert property (p_lamp_off) else $error("lamp lit with control bit clear");

   property p_steady_attr;
      @(posedge ref_clk) disable iff (!rstN)
      (ctrlBits_q[0] && !flashAttr_q[0]) |=> lampOn[0];
   endproperty
   a_steady_attr: assert property (p_steady_attr) else $error("steady lamp not lit");

   property p_press_notify;
      @(posedge ref_clk) disable iff (!rstN)
      pressS2_q[0] |=> pressLatch_q[0];
   endproperty
   a_press_notify: assert property (p_press_notify) else $error("press not recorded");

   property p_inter_on_phase;
      @(posedge ref_clk) disable iff (!rstN)
      (interReq_q && !contReq_q && halfCnt_q == '0 && !phase_q) |=> buzzer;
   endproperty
   a_inter_on_phase: assert property (p_inter_on_phase) else $error("intermittent on phase missing");
endmodule : terminal_status_lamp_control

// >>> lamp_ctrl_pkg.sv
package lamp_ctrl_pkg;
   // status-control word field positions
   localparam int DISP_BIT    = 15;
   localparam int CONT_BIT    = 13;
   localparam int INTER_BIT   = 12;
   localparam int CTRL_LO_BIT = 8;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   // register indices on the plain register port
   localparam logic [3:0] REG_STATUS  = 4'h0;
   localparam logic [3:0] REG_LAMP    = 4'h1;
   localparam logic [3:0] REG_FLASH   = 4'h2;
   localparam logic [3:0] REG_PRESS   = 4'h3;
   localparam logic [3:0] REG_OUTSTAT = 4'h4;
   // timing
   localparam int CLK_HZ        = 100_000_000;
   localparam int BEEP_HALF_MS  = 500;
   localparam int BEEP_HALF_CYC = (CLK_HZ / 1000) * BEEP_HALF_MS;
endpackage : lamp_ctrl_pkg

// >>> host_model.sv
`timescale 1ns/10ps
module host_model (
   input  wire logic        ref_clk,
   output logic      [3:0]  regAddr,
   output logic      [15:0] regWrData,
   output logic             regWrStb,
   output logic             regRdStb,
   input  wire logic [15:0] regRdData
);
   initial begin
      regAddr = 4'h0;
      regWrData = 16'h0000;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
   end
   // words only land in the data-memory style register file, never a timer or counter
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge ref_clk);
      regWrStb <= 1'b0;
      // parked data is the inverse so a stale value never looks valid
      regWrData <= ~d;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge ref_clk);
      regRdStb <= 1'b0;
      #1 d = regRdData;
   endtask : rd
   // undoing a change rewrites bits 8 to 15 with their old values
   task automatic undo(input logic [15:0] old);
      wr(lamp_ctrl_pkg::REG_STATUS, {old[15:8], 8'h00});
   endtask : undo
endmodule : host_model

// >>> testbench.sv
`timescale 1ns/10ps
module testbench;
   logic        ref_clk, rst_b;
   logic [3:0]  regAddr;
   logic [15:0] regWrData, regRdData, rdv;
   logic        regWrStb, regRdStb, screenOn, buzzer;
   logic [7:0]  swPressed, lampOn, swHighlight, p;
   int          miscompares, num_checks, cyc, seed, n;
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   host_model host_i (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
      .regRdStb(regRdStb), .regRdData(regRdData));
   terminal_status_lamp_control #(.HALF_CYC(10)) terminal_status_lamp_control_i (.ref_clk(ref_clk),
      .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .swPressed(swPressed), .screenOn(screenOn), .buzzer(buzzer), .lampOn(lampOn),
      .swHighlight(swHighlight));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // expected {screen, buzzer} a short while after a status word lands; both bits pick continuous
   function automatic logic [1:0] exp_out(input logic [15:0] w);
      return {w[lamp_ctrl_pkg::DISP_BIT], w[lamp_ctrl_pkg::CONT_BIT] | w[lamp_ctrl_pkg::INTER_BIT]};
   endfunction : exp_out
   task automatic ones(input int len, input logic [7:0] msk, output int c);
      c = 0;
      repeat (len) begin
         @(posedge ref_clk);
         #1 c += ((buzzer & msk[7]) | (|(lampOn & msk[6:0]))) ? 1 : 0;
      end
   endtask : ones
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc = 0;
      seed = 32'h3b142c91;
      miscompares = 0;
      num_checks = 0;
      rst_b = 1'b0;
      swPressed = 8'h00;
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      host_i.wr(lamp_ctrl_pkg::REG_STATUS, 16'h0000);
      host_i.rd(lamp_ctrl_pkg::REG_OUTSTAT, rdv);
      chk("unarmed", 16'h0000, rdv);
      host_i.wr(lamp_ctrl_pkg::REG_STATUS, 16'ha000);
      repeat (3) @(posedge ref_clk);
      #1 chk("cont", {14'h0, exp_out(16'ha000)}, {14'h0, screenOn, buzzer});
      host_i.rd(lamp_ctrl_pkg::REG_OUTSTAT, rdv);
      chk("armed", 16'h0007, rdv);
      host_i.wr(lamp_ctrl_pkg::REG_STATUS, 16'hb000);
      ones(25, 8'h80, n);
      chk("both", 16'd25, 16'(n));
      host_i.wr(lamp_ctrl_pkg::REG_STATUS, 16'h9000);
      repeat (3) @(posedge ref_clk);
      ones(40, 8'h80, n);
      chk("inter", 16'd20, 16'(n));
      host_i.wr(lamp_ctrl_pkg::REG_STATUS, 16'h8000);
      repeat (3) @(posedge ref_clk);
      #1 chk("quiet", {14'h0, exp_out(16'h8000)}, {14'h0, screenOn, buzzer});
      host_i.undo(16'h0000);
      repeat (3) @(posedge ref_clk);
      #1 chk("undo", 16'h0000, {14'h0, screenOn, buzzer});
      $display("status tests done");
      host_i.wr(lamp_ctrl_pkg::REG_FLASH, 16'h0000);
      repeat (8) begin
         rdv = 16'($random(seed));
         host_i.wr(lamp_ctrl_pkg::REG_LAMP, rdv);
         repeat (3) @(posedge ref_clk);
         #1 chk("lamps", rdv, {swHighlight, lampOn});
      end
      host_i.wr(lamp_ctrl_pkg::REG_FLASH, 16'h0001);
      host_i.wr(lamp_ctrl_pkg::REG_LAMP, 16'h0001);
      ones(40, 8'h01, n);
      chk("flash", 16'd20, 16'(n));
      host_i.wr(lamp_ctrl_pkg::REG_LAMP, 16'h0000);
      ones(30, 8'h01, n);
      chk("flash off", 16'd0, 16'(n));
      $display("lamp tests done");
      p = 8'($random(seed)) | 8'h01;
      swPressed <= p;
      repeat (4) @(posedge ref_clk);
      host_i.rd(lamp_ctrl_pkg::REG_PRESS, rdv);
      chk("press", {8'h00, p}, rdv);
      swPressed <= 8'h00;
      repeat (4) @(posedge ref_clk);
      host_i.wr(lamp_ctrl_pkg::REG_PRESS, 16'h00ff);
      host_i.rd(lamp_ctrl_pkg::REG_PRESS, rdv);
      chk("press clr", 16'h0000, rdv);
      host_i.rd(4'h5, rdv);
      chk("unmapped", 16'h0000, rdv);
      $display("notify tests done");
      wrap_up();
   end
endmodule : testbench
